// ==== logic/sep_defs.svh ====
/*
 Constants of the serial EEPROM instruction and status-protection block.
 Assumes it is included by bare name after the package.
*/
//
// Contract
// - Each instruction opens with one opcode byte; 06h sets, 04h clears the latch.
// - Opcode 05h reads the status byte out on the serial output.
// - Opcode 01h writes status, followed by one data byte.
// - Opcode 03h is the array read command.
// - Opcode 02h is the array write command.
// - Opcode 83h is id read or lock read; 82h id write or lock.
// - Address bit 10 high picks the lock operation, low the id page data.
// - Unknown opcode deselects the device until chip select rises.
// - Latch-set executes on chip select rising; nothing else sets the latch.
// - Latch clears at power-up, on latch-clear, and when writes complete.
// - With the latch clear, array and status writes are rejected.
// - Status read works any time, also in write cycles, and repeats.
// - Busy flag reads one exactly while a self-timed write runs.
// - Protect size and lock bits are non-volatile, set by status write only.
// - Protect size 00 none, 01 C00h-FFFh, 10 800h-FFFh, 11 all.
// - Valid status write starts timed cycle; busy during, latch clears at end.
// - New lock and protect values apply only after the cycle completes.
// - Status write leaves b6..b4, b1, b0 alone; b6..b4 read zero.
// - Lock bit zero: status write accepted with latch set, any protect pin.
// - Lock bit one and protect pin low: status writes rejected.
// - Hard lock mode follows either order of lock bit and pin.
// - Hard lock ends only when the protect pin goes high.
// - Array uses address bits 11..0; bits 15..12 are ignored.
// - Input sampled on clock rising edge, output from falling edge, modes 0 and 3.
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH
`define SEP_OP_SET_LATCH   8'h06
`define SEP_OP_CLR_LATCH   8'h04
`define SEP_OP_STAT_READ   8'h05
`define SEP_OP_STAT_WRITE  8'h01
`define SEP_OP_ARR_READ    8'h03
`define SEP_OP_ARR_WRITE   8'h02
`define SEP_OP_ID_READ     8'h83
`define SEP_OP_ID_WRITE    8'h82
`define SEP_ID_SEL_BIT     10
`define SEP_PIN_RST        4'h_c
`define SEP_PIN_WP         3
`define SEP_PIN_CS         2
`define SEP_PIN_SCLK       1
`define SEP_PIN_MOSI       0
`define SEP_SR_LOCK        7
`define SEP_SR_SIZE_HI     3
`define SEP_SR_SIZE_LO     2
`define SEP_NV_LOCK        2
`define SEP_LAST_BIT       3'h7
`define SEP_BIT_ZERO       3'h0
`define SEP_QUARTER_HI     2'h3
`define SEP_TW_CYCLES      125000
`define SEP_TW_ONE         18'h0_0001
`endif

// ==== logic/sep_pkg.sv ====
/*
 Types of the serial EEPROM instruction and status-protection block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sep_pkg;
    typedef enum logic [2:0] {
        OP_NONE, OP_ARR_READ, OP_ARR_WRITE, OP_ID_READ, OP_ID_WRITE, OP_LOCK_READ, OP_LOCK_ID
    } sep_op_e;
    typedef enum {
        ST_IDLE, ST_OPC, ST_WAIT, ST_STATUS_READ_CMD, ST_STATUS_WRITE_CMD, ST_STATUS_WRITE_CMD_END,
        ST_ADDR_HI, ST_ADDR_LO, ST_DATA0, ST_DATA, ST_XFER, ST_IGNORE
    } sep_state_e;
    typedef struct packed {
        sep_op_e     op;
        logic [15:0] addr;
    } sep_cmd_s;
    typedef struct packed {
        logic lock;
        logic size_hi;
        logic size_lo;
    } sep_nv_s;
endpackage

// ==== logic/sep_core.sv ====
/*
 Instruction decoder, status register and write protection of a serial EEPROM.
 Assumes pins arrive asynchronously, array logic completes writes via a done pulse,
 and a non-volatile store presents the saved status bits at reset.
*/
`timescale 1ns/1ns
`include "sep_defs.svh"
module sep_core #(
    parameter int unsigned SR_WRITE_CYCLES = `SEP_TW_CYCLES
) (
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              rst_n_in,
    // Serial pins
    input  wire logic              sclk_in,
    input  wire logic              cs_n_in,
    input  wire logic              mosi_in,
    input  wire logic              wp_n_in,
    output logic                   miso_out,
    output logic                   miso_oe_n_out,
    // Non-volatile store
    input  wire sep_pkg::sep_nv_s  nv_status_in,
    output sep_pkg::sep_nv_s       nv_status_out,
    output logic                   nv_write_out,
    // Array side
    output sep_pkg::sep_cmd_s      cmd_out,
    output logic                   cmd_valid_out,
    output logic [7:0]             rx_byte_out,
    output logic                   rx_byte_valid_out,
    output logic                   array_write_start_out,
    input  wire logic              array_write_done_in,
    // Status view
    output logic [7:0]             status_out,
    output logic                   hard_lock_mode_out
);
    import sep_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [7:0] status_byte(input sep_nv_s nv, input logic write_latch_flag,
                                               input logic busy);
        status_byte = {nv.lock, 3'h0, nv.size_hi, nv.size_lo, write_latch_flag, busy};
    endfunction

    function automatic logic in_protected(input sep_nv_s nv, input logic [15:0] addr);
        logic [1:0] size;
        size = {nv.size_hi, nv.size_lo};
        unique case (size)
            2'h0: in_protected = 1'b0;
            2'h1: in_protected = (addr[11:10] == `SEP_QUARTER_HI);
            2'h2: in_protected = addr[11];
            2'h3: in_protected = 1'b1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    logic [3:0] pin_raw;
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic [3:0] pin_s3_q;
    logic [3:0] pin_q;
    logic [3:0] pin_prev_q;

    assign pin_raw = {wp_n_in, cs_n_in, sclk_in, mosi_in};

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pin_s1_q <= `SEP_PIN_RST;
            pin_s2_q <= `SEP_PIN_RST;
            pin_s3_q <= `SEP_PIN_RST;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // A change counts only once the second and third stages agree
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pin_q      <= `SEP_PIN_RST;
            pin_prev_q <= `SEP_PIN_RST;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (pin_s2_q[i] == pin_s3_q[i]) begin
                    pin_q[i] <= pin_s3_q[i];
                end
            end
            pin_prev_q <= pin_q;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic mosi_bit;
    logic wp_n;

    assign sclk_rise = pin_q[`SEP_PIN_SCLK] & ~pin_prev_q[`SEP_PIN_SCLK];
    assign sclk_fall = ~pin_q[`SEP_PIN_SCLK] & pin_prev_q[`SEP_PIN_SCLK];
    assign cs_fall   = ~pin_q[`SEP_PIN_CS] & pin_prev_q[`SEP_PIN_CS];
    assign cs_rise   = pin_q[`SEP_PIN_CS] & ~pin_prev_q[`SEP_PIN_CS];
    assign mosi_bit  = pin_q[`SEP_PIN_MOSI];
    assign wp_n      = pin_q[`SEP_PIN_WP];

    // ------------------------------------------------------------
    // Selection, armed only after chip select seen high
    // ------------------------------------------------------------
    logic armed_q;
    logic sel_q;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            armed_q <= 1'b0;
            sel_q   <= 1'b0;
        end else begin
            if (pin_q[`SEP_PIN_CS]) begin
                armed_q <= 1'b1;
            end
            if (cs_rise) begin
                sel_q <= 1'b0;
            end else if (cs_fall && armed_q) begin
                sel_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Shift register and bit counter
    // ------------------------------------------------------------
    logic [7:0] rx_sh_q;
    logic [2:0] bit_q;
    logic       byte_done;
    logic [7:0] new_byte;

    assign new_byte  = {rx_sh_q[6:0], mosi_bit};
    assign byte_done = sel_q && sclk_rise && (bit_q == `SEP_LAST_BIT);

    always_ff @(posedge clock_in) begin
        if (!rst_n_in || !sel_q) begin
            rx_sh_q <= 8'h00;
            bit_q   <= `SEP_BIT_ZERO;
        end else if (sclk_rise) begin
            rx_sh_q <= new_byte;
            bit_q   <= bit_q + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Instruction state machine
    // ------------------------------------------------------------
    sep_state_e state_q;
    logic [7:0] opc_q;
    sep_op_e    op_q;
    logic [15:0] addr_q;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in || cs_rise) begin
            state_q <= ST_IDLE;
        end else if (cs_fall && armed_q) begin
            state_q <= ST_OPC;
        end else if (byte_done) begin
            unique case (state_q)
                ST_OPC: begin
                    unique case (new_byte)
                        `SEP_OP_SET_LATCH,
                        `SEP_OP_CLR_LATCH:  state_q <= ST_WAIT;
                        `SEP_OP_STAT_READ:  state_q <= ST_STATUS_READ_CMD;
                        `SEP_OP_STAT_WRITE: state_q <= ST_STATUS_WRITE_CMD;
                        `SEP_OP_ARR_READ,
                        `SEP_OP_ARR_WRITE,
                        `SEP_OP_ID_READ,
                        `SEP_OP_ID_WRITE:   state_q <= ST_ADDR_HI;
                        default:            state_q <= ST_IGNORE;
                    endcase
                end
                ST_STATUS_WRITE_CMD:    state_q <= ST_STATUS_WRITE_CMD_END;
                ST_ADDR_HI: state_q <= ST_ADDR_LO;
                ST_ADDR_LO: begin
                    if (op_q == OP_ARR_WRITE || op_q == OP_ID_WRITE || op_q == OP_LOCK_ID) begin
                        state_q <= ST_DATA0;
                    end else begin
                        state_q <= ST_XFER;
                    end
                end
                ST_DATA0:   state_q <= ST_DATA;
                // Surplus bits after a complete command void it
                ST_WAIT,
                ST_STATUS_WRITE_CMD_END: state_q <= ST_IGNORE;
                ST_IDLE, ST_STATUS_READ_CMD, ST_DATA, ST_XFER, ST_IGNORE: state_q <= state_q;
            endcase
        end
    end

    // Opcode and array operation kind
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            opc_q <= 8'h00;
            op_q  <= OP_NONE;
        end else if (byte_done && state_q == ST_OPC) begin
            opc_q <= new_byte;
            unique case (new_byte)
                `SEP_OP_ARR_READ:  op_q <= OP_ARR_READ;
                `SEP_OP_ARR_WRITE: op_q <= OP_ARR_WRITE;
                `SEP_OP_ID_READ:   op_q <= OP_ID_READ;
                `SEP_OP_ID_WRITE:  op_q <= OP_ID_WRITE;
                default:           op_q <= OP_NONE;
            endcase
        end else if (byte_done && state_q == ST_ADDR_HI && new_byte[`SEP_ID_SEL_BIT - 8]) begin
            if (op_q == OP_ID_READ) begin
                op_q <= OP_LOCK_READ;
            end else if (op_q == OP_ID_WRITE) begin
                op_q <= OP_LOCK_ID;
            end
        end
    end

    // Address capture, high byte first
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            addr_q <= 16'h0000;
        end else if (byte_done && (state_q == ST_ADDR_HI || state_q == ST_ADDR_LO)) begin
            addr_q <= {addr_q[7:0], new_byte};
        end
    end

    // ------------------------------------------------------------
    // Execution at chip select rising
    // ------------------------------------------------------------
    sep_nv_s nv_q;
    sep_nv_s nv_pend_q;
    logic    wel_q;
    logic    sr_busy_q;
    logic    arr_busy_q;
    logic    busy;
    logic    hard_lock;
    logic    at_boundary;
    logic    exec_set;
    logic    exec_clr;
    logic    exec_status_write_cmd;
    logic    exec_wr;
    logic    sr_done;
    logic [17:0] tw_cnt_q;

    assign busy        = sr_busy_q | arr_busy_q;
    assign hard_lock   = nv_q.lock & ~wp_n;
    assign at_boundary = cs_rise && (bit_q == `SEP_BIT_ZERO);
    assign exec_set    = at_boundary && state_q == ST_WAIT && opc_q == `SEP_OP_SET_LATCH;
    assign exec_clr    = at_boundary && state_q == ST_WAIT && opc_q == `SEP_OP_CLR_LATCH;
    assign exec_status_write_cmd   = at_boundary && state_q == ST_STATUS_WRITE_CMD_END && wel_q && !busy
                         && !hard_lock;
    assign exec_wr     = at_boundary && state_q == ST_DATA && op_q == OP_ARR_WRITE
                         && wel_q && !busy && !in_protected(nv_q, addr_q);
    assign sr_done     = sr_busy_q && (tw_cnt_q == `SEP_TW_ONE);

    // Self-timed status write cycle
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            sr_busy_q <= 1'b0;
            tw_cnt_q  <= 18'h0_0000;
            nv_pend_q <= '0;
        end else if (exec_status_write_cmd) begin
            sr_busy_q <= 1'b1;
            tw_cnt_q  <= 18'(SR_WRITE_CYCLES);
            nv_pend_q <= {rx_sh_q[`SEP_SR_LOCK], rx_sh_q[`SEP_SR_SIZE_HI],
                          rx_sh_q[`SEP_SR_SIZE_LO]};
        end else if (sr_done) begin
            sr_busy_q <= 1'b0;
        end else if (sr_busy_q) begin
            tw_cnt_q <= tw_cnt_q - `SEP_TW_ONE;
        end
    end

    // Array write cycle ends on the array's done pulse
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            arr_busy_q <= 1'b0;
        end else if (exec_wr) begin
            arr_busy_q <= 1'b1;
        end else if (array_write_done_in) begin
            arr_busy_q <= 1'b0;
        end
    end

    // Write latch; a set in the same cycle as a clear wins
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            wel_q <= 1'b0;
        end else if (exec_set) begin
            wel_q <= 1'b1;
        end else if (exec_clr || sr_done || (arr_busy_q && array_write_done_in)) begin
            wel_q <= 1'b0;
        end
    end

    // Non-volatile bits, reloaded from the store at reset
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            nv_q <= nv_status_in;
        end else if (sr_done) begin
            nv_q <= nv_pend_q;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            nv_write_out <= 1'b0;
        end else begin
            nv_write_out <= sr_done;
        end
    end

    // ------------------------------------------------------------
    // Status read output, shifted on falling edges
    // ------------------------------------------------------------
    logic [2:0] out_cnt_q;
    logic [7:0] status_now;

    assign status_now = status_byte(nv_q, wel_q, busy);

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            out_cnt_q <= `SEP_LAST_BIT;
            miso_out  <= 1'b0;
        end else if (byte_done && state_q == ST_OPC) begin
            out_cnt_q <= `SEP_LAST_BIT;
        end else if (sclk_fall && sel_q && state_q == ST_STATUS_READ_CMD) begin
            miso_out  <= status_now[out_cnt_q];
            out_cnt_q <= out_cnt_q - 3'h1;
        end
    end

    assign miso_oe_n_out = ~(sel_q && state_q == ST_STATUS_READ_CMD);

    // ------------------------------------------------------------
    // Array side handover
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rx_byte_out           <= 8'h00;
            rx_byte_valid_out     <= 1'b0;
            array_write_start_out <= 1'b0;
        end else begin
            rx_byte_valid_out     <= byte_done && (state_q == ST_DATA0 || state_q == ST_DATA);
            array_write_start_out <= exec_wr;
            if (byte_done) begin
                rx_byte_out <= new_byte;
            end
        end
    end

    assign cmd_out            = '{op: op_q, addr: addr_q};
    assign cmd_valid_out      = sel_q && (state_q == ST_DATA0 || state_q == ST_DATA
                                || state_q == ST_XFER);
    assign status_out         = status_now;
    assign nv_status_out      = nv_q;
    assign hard_lock_mode_out = hard_lock;
endmodule

// ==== verification/sep_spi_master.sv ====
/*
 SPI bus master model in mode 0 driving the serial pins of sep_core.
 Assumes a 25 MHz system clock; one serial clock period is eight of its cycles.
*/
`timescale 1ns/1ns
module sep_spi_master (
    // System side
    input  wire logic clock_in,
    // Serial pins
    input  wire logic miso_in,
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      mosi_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    // ----------------------------------------
    // One framed transfer, MSB first
    // ----------------------------------------
    task automatic frame(input logic [31:0] d, input int n, output logic [15:0] rx);
        rx = 16'h0;
        tick(1);
        cs_n_out <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_out <= d[i];
            tick(4);
            sclk_out <= 1'b1;
            tick(3);
            #1 rx = {rx[14:0], miso_in};
            tick(1);
            sclk_out <= 1'b0;
        end
        tick(4);
        cs_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
        tick(8);
    endtask
endmodule

// ==== verification/sep_core_monitor.sv ====
/*
 Concurrent checks on the ports of sep_core.
 Assumes the pin filters settle within eight system clocks.
*/
`timescale 1ns/1ns
module sep_core_monitor #(
    parameter int unsigned SR_WRITE_CYCLES = 20
) (
    // Clock, reset and pins
    input wire logic             clock_in,
    input wire logic             rst_n_in,
    input wire logic             cs_n_in,
    input wire logic             wp_n_in,
    input wire logic             miso_oe_n_out,
    // Status and write side
    input wire sep_pkg::sep_nv_s nv_status_out,
    input wire logic             nv_write_out,
    input wire logic             array_write_start_out,
    input wire logic             array_write_done_in,
    input wire logic [7:0]       status_out,
    input wire logic             hard_lock_mode_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // ----------------------------------------
    // Commit of the non-volatile bits
    // ----------------------------------------
    sequence commit_s;
        $fell(status_out[0]) && nv_write_out ##1 !nv_write_out;
    endsequence
    nv_commit_a: assert property ($changed(nv_status_out) |-> commit_s)
        else $error("Protect bits changed outside a write cycle end");
    commit_clears_a: assert property (nv_write_out |-> !status_out[1] ##1 !nv_write_out)
        else $error("Latch still set after status commit");
    status_map_a: assert property (status_out[7:2] == {nv_status_out.lock, 3'h0,
        nv_status_out.size_hi, nv_status_out.size_lo}) else $error("Status byte layout wrong");
    cs_idle_a: assert property (cs_n_in [*8] |-> miso_oe_n_out)
        else $error("Serial output driven while deselected");
    hard_enter_a: assert property ((status_out[7] && !wp_n_in) [*8] |-> hard_lock_mode_out)
        else $error("Hard lock not entered");
    hard_leave_a: assert property (wp_n_in [*8] |-> !hard_lock_mode_out)
        else $error("Hard lock kept with protect pin high");
    start_busy_a: assert property (array_write_start_out |-> ##[0:1] status_out[0])
        else $error("Busy missing after write start");
    busy_latch_a: assert property ($rose(status_out[0]) |-> $past(status_out[1]))
        else $error("Write cycle started without latch");
    done_clear_a: assert property (array_write_done_in && status_out[0] |=>
        !status_out[1] && !status_out[0]) else $error("Latch or busy kept after done");
    latch_set_a: assert property ($rose(status_out[1]) |-> $past(cs_n_in))
        else $error("Latch set while selected");
endmodule
bind sep_core sep_core_monitor #(.SR_WRITE_CYCLES(SR_WRITE_CYCLES)) u_mon (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .wp_n_in(wp_n_in),
    .miso_oe_n_out(miso_oe_n_out), .nv_status_out(nv_status_out),
    .nv_write_out(nv_write_out), .array_write_start_out(array_write_start_out),
    .array_write_done_in(array_write_done_in), .status_out(status_out),
    .hard_lock_mode_out(hard_lock_mode_out));

// ==== verification/tb_sep_core.sv ====
/*
 Self-checking bench of sep_core with a bit-level model of the status logic.
 Assumes sep_spi_master as bus master and a bench store for the protect bits.
*/
`timescale 1ns/1ns
module tb_sep_core;
    import sep_pkg::*;
    logic        clock_in, rst_n_in, wp_n_in, array_write_done_in;
    logic        sclk, cs_n, mosi, miso, dout, last_q, oe_n, nv_wr, aw_start, hard, p;
    logic        lock, sh, sl, lat, cval, rxv;
    logic [7:0]  status, v, op, rxb;
    logic [5:0]  dly_q;
    logic [15:0] rx, cv_addr;
    sep_nv_s     nv_in, nv_out;
    sep_cmd_s    cmd_q;
    int          fails = 0, check_count = 0, starts = 0, exp_starts = 0, seed = 32'h501b;
    int          rx_pulses = 0, exp_pulses = 0;
    logic [11:0] addrs [4] = '{12'h7ff, 12'h800, 12'hbff, 12'hc00};

    sep_core #(.SR_WRITE_CYCLES(300)) DUT (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .sclk_in(sclk), .cs_n_in(cs_n), .mosi_in(mosi), .wp_n_in(wp_n_in), .miso_out(dout),
        .miso_oe_n_out(oe_n), .nv_status_in(nv_in), .nv_status_out(nv_out),
        .nv_write_out(nv_wr), .cmd_out(cmd_q), .cmd_valid_out(cval), .rx_byte_out(rxb),
        .rx_byte_valid_out(rxv), .array_write_start_out(aw_start),
        .array_write_done_in(array_write_done_in), .status_out(status),
        .hard_lock_mode_out(hard));
    sep_spi_master M (.clock_in(clock_in), .miso_in(miso), .sclk_out(sclk), .cs_n_out(cs_n),
        .mosi_out(mosi));
    assign miso = oe_n ? ~last_q : dout;

    initial begin
        clock_in = 1'b0;
        forever #20 clock_in = ~clock_in;
    end
    // Array completes seven cycles after start; store saves committed bits
    always @(posedge clock_in) begin
        dly_q <= {dly_q[4:0], aw_start};
        array_write_done_in <= dly_q[5];
        if (aw_start) starts <= starts + 1;
        if (rxv) rx_pulses <= rx_pulses + 1;
        if (cval) cv_addr <= cmd_q.addr;
        if (nv_wr) nv_in <= nv_out;
        if (!oe_n) last_q <= dout;
    end
    initial begin
        #2000000;
        fails++;
        end_of_test;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] st(input logic b);
        return {lock, 3'h0, sh, sl, lat, b};
    endfunction
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        if (fails == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task cmd(input logic [31:0] d, input int n);
        M.frame(d, n, rx);
        #1;
    endtask
    task wait_idle;
        int k;
        for (k = 0; k < 3000 && status[0] !== 1'b0; k++) begin
            M.tick(1);
            #1;
        end
        if (k == 3000) begin
            fails++;
            end_of_test;
        end
    endtask
    task set_write_latch_cmd;
        cmd(8'h06, 8);
        lat = 1'b1;
        chk("latch set", status, st(0));
    endtask
    task srw(input logic [7:0] d);
        cmd({8'h01, d}, 16);
        if (lat && !(lock && !wp_n_in)) begin
            chk("busy", status, st(1));
            wait_idle;
            {lock, sh, sl, lat} = {d[7], d[3], d[2], 1'b0};
        end
        chk("status write", status, st(0));
    endtask
    task aw(input logic [11:0] a);
        v = $random(seed);
        set_write_latch_cmd;
        p = (sh && sl) || (sh && a >= 12'h800) || (sl && a >= 12'hc00);
        cmd({8'h02, v[7:5], 1'b0, a, v}, 32);
        exp_pulses++;
        wait_idle;
        if (!p) {lat, exp_starts} = {1'b0, exp_starts + 1};
        chk("write starts", 16'(starts), 16'(exp_starts));
        chk("latch after write", status, st(0));
        chk("decoded op", 16'(cmd_q.op), 16'(OP_ARR_WRITE));
        chk("data byte", 16'(rxb), 16'(v));
        chk("byte pulses", 16'(rx_pulses), 16'(exp_pulses));
        chk("write address", cv_addr, {v[7:5], 1'b0, a});
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_n_in, wp_n_in, array_write_done_in, dly_q, last_q} = 10'h100;
        v = $random(seed);
        nv_in = v[2:0];
        {lock, sh, sl, lat} = {v[2:0], 1'b0};
        M.tick(6);
        rst_n_in <= 1'b1;
        M.tick(8);
        #1 chk("reset", status, st(0));
        srw(8'h8c);
        set_write_latch_cmd;
        cmd(8'h04, 8);
        lat = 1'b0;
        chk("latch clear", status, st(0));
        cmd({8'h83, 16'h0400}, 24);
        chk("lock read op", 16'(cmd_q.op), 16'(OP_LOCK_READ));
        cmd({8'h83, 16'h0000}, 24);
        chk("id read op", 16'(cmd_q.op), 16'(OP_ID_READ));
        cmd({8'h82, 16'h0400, 8'h5a}, 32);
        exp_pulses++;
        chk("lock id op", 16'(cmd_q.op), 16'(OP_LOCK_ID));
        chk("id data byte", 16'(rxb), 16'h005a);
        cmd({8'h03, 16'hf123}, 24);
        chk("read op", 16'(cmd_q.op), 16'(OP_ARR_READ));
        chk("read address", cv_addr, 16'hf123);
        op = $random(seed);
        while (op inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h82, 8'h83})
            op = $random(seed);
        cmd({op, 8'h06}, 16);
        chk("unknown op", status, st(0));
        set_write_latch_cmd;
        cmd({8'h01, 8'h8c, 1'b0}, 17);
        chk("odd length", status, st(0));
        v = $random(seed) | 8'h80;
        cmd({8'h01, v}, 16);
        cmd({8'h05, 16'h0}, 24);
        chk("status read", rx, {st(1), st(1)});
        wait_idle;
        {lock, sh, sl, lat} = {v[7], v[3], v[2], 1'b0};
        chk("status commit", status, st(0));
        M.tick(1);
        wp_n_in <= 1'b0;
        M.tick(9);
        chk("hard lock", 16'(hard), 16'h1);
        set_write_latch_cmd;
        srw(8'h00);
        M.tick(1);
        wp_n_in <= 1'b1;
        M.tick(9);
        chk("hard lock off", 16'(hard), 16'h0);
        srw(8'h00);
        M.tick(1);
        wp_n_in <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            set_write_latch_cmd;
            srw({4'h0, 2'(s), 2'h0});
            foreach (addrs[i]) aw(addrs[i]);
        end
        set_write_latch_cmd;
        rst_n_in <= 1'b0;
        M.tick(6);
        rst_n_in <= 1'b1;
        lat = 1'b0;
        M.tick(8);
        #1 chk("second reset", status, st(0));
        end_of_test;
    end
endmodule
